//--- core/port_e_gpio.sv
// Behaviour
// - Eight-bit write-only direction register; reads give a fixed filler value
// - Direction clears on power-on reset and hardware standby, else retained
// - Modes 1,2,4,5,6 with 8-bit bus: direction bit 1 outputs, 0 inputs
// - Modes 1,2,4,5,6 with 16-bit bus: pins carry upper data bus
// - Modes 3 and 7: per-bit direction, 1 output, 0 input
// - Eight-bit read/write output value register drives output pins
// - Output value and pull-up registers clear on power-on and hardware standby
// - Read-only readback register; writes to it are ignored
// - Readback gives output bit where direction 1, pin level where 0
// - Readback follows pins after reset and in hardware standby, holds during manual reset and software standby
// - Eight-bit read/write pull-up register, one bit per pin
// - Pull-up on only for input pin with pull-up bit set in port mode
// - Pull-ups forced off in expanded modes with 16-bit bus
// - Pull-ups off after power-on and hardware standby, held otherwise
`timescale 1ns/1ps
`default_nettype none
module port_e_gpio #(
  parameter int PINS = port_e_pkg::PORT_PINS
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  input wire logic hwStandby,
  input wire logic manualReset,
  input wire logic swStandby,
  input wire logic [port_e_pkg::MODE_W-1:0] opMode,
  input wire logic busWide,
  input wire logic [port_e_pkg::ADDR_W-1:0] regAddr,
  input wire logic [port_e_pkg::DATA_W-1:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [port_e_pkg::DATA_W-1:0] regRdData,
  input wire logic [PINS-1:0] pinIn,
  output logic [PINS-1:0] pinOut,
  output logic [PINS-1:0] pinOe,
  output logic [PINS-1:0] pullupOn,
  input wire logic [PINS-1:0] busDataOut,
  input wire logic busDataOe,
  output logic [PINS-1:0] busDataIn
);
  import port_e_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Parameter check
  if (PINS != DATA_W) begin : gBadParam
    $error("port_e_gpio needs one register bit per pin");
  end

  ////////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    logic [PINS-1:0] direction;
    logic [PINS-1:0] outputValue;
    logic [PINS-1:0] pullupEnable;
    logic [PINS-1:0] readback;
    logic [PINS-1:0] pinOut;
    logic [PINS-1:0] pinOe;
    logic [PINS-1:0] pullupOn;
    logic [PINS-1:0] busDataIn;
    logic [DATA_W-1:0] rdData;
    owner_e owner;
  } port_state_s;

  localparam port_state_s RESET_STATE = '{
    direction: RESET_PIN_DIRECTION,
    outputValue: RESET_OUTPUT_VALUE,
    pullupEnable: RESET_PULLUP_ENABLE,
    readback: '0,
    pinOut: '0,
    pinOe: '0,
    pullupOn: '0,
    busDataIn: '0,
    rdData: '0,
    owner: OWN_GPIO
  };

  port_state_s cur;
  port_state_s next_cur;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchroniser
  logic [PINS-1:0] pinSync;

  pin_sync #(
    .WIDTH(PINS),
    .STAGES(SYNC_STAGES)
  ) uPinSync (
    .mclk(mclk),
    .rst(rst),
    .ce(ce),
    .asyncIn(pinIn),
    .syncOut(pinSync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Mode decode
  logic expandedMode;
  logic portMode;
  logic holdState;
  logic busAccessOk;
  owner_e ownerNow;

  always_comb begin
    case (opMode)
      MODE_1, MODE_2, MODE_4, MODE_5, MODE_6: begin
        expandedMode = 1'b1;
      end
      MODE_0, MODE_3, MODE_7: begin
        expandedMode = 1'b0;
      end
      default: begin
        expandedMode = 1'b0;
      end
    endcase
  end

  // Bus width only matters in expanded modes
  assign portMode = !(expandedMode && busWide);

  // Manual reset and software standby freeze pins and readback
  assign holdState = manualReset || swStandby;

  // Registers only take writes while the processor runs; reads are not gated
  assign busAccessOk = !hwStandby && !manualReset && !swStandby;

  always_comb begin
    if (hwStandby) begin
      ownerNow = OWN_STANDBY;
    end else if (portMode) begin
      ownerNow = OWN_GPIO;
    end else begin
      ownerNow = OWN_DATABUS;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-pin function
  logic [PINS-1:0] pinOutNow;
  logic [PINS-1:0] pinOeNow;
  logic [PINS-1:0] pullupNow;
  logic [PINS-1:0] readbackNow;

  for (genvar i = 0; i < PINS; i++) begin : gPin
    always_comb begin
      case (ownerNow)
        OWN_GPIO: begin
          pinOutNow[i] = cur.outputValue[i];
          pinOeNow[i] = cur.direction[i];
          pullupNow[i] = !cur.direction[i] && cur.pullupEnable[i];
        end
        OWN_DATABUS: begin
          pinOutNow[i] = busDataOut[i];
          pinOeNow[i] = busDataOe;
          pullupNow[i] = 1'b0;
        end
        OWN_STANDBY: begin
          pinOutNow[i] = 1'b0;
          pinOeNow[i] = 1'b0;
          pullupNow[i] = 1'b0;
        end
        default: begin
          pinOutNow[i] = 1'b0;
          pinOeNow[i] = 1'b0;
          pullupNow[i] = 1'b0;
        end
      endcase
      if (cur.direction[i]) begin
        readbackNow[i] = cur.outputValue[i];
      end else begin
        readbackNow[i] = pinSync[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register file and pin state
  logic [DATA_W-1:0] statusWord;

  always_comb begin
    statusWord = '0;
    statusWord[STATUS_OWNER_LSB +: STATUS_OWNER_W] = cur.owner;
    statusWord[STATUS_WIDE_BIT] = !portMode;
  end

  always_comb begin
    next_cur = cur;
    next_cur.owner = ownerNow;
    next_cur.busDataIn = pinSync;

    // Register writes; the readback address takes no write
    if (regWr && busAccessOk) begin
      case (regAddr)
        ADDR_PIN_DIRECTION: begin
          next_cur.direction = regWrData;
        end
        ADDR_OUTPUT_VALUE: begin
          next_cur.outputValue = regWrData;
        end
        ADDR_PULLUP_ENABLE: begin
          next_cur.pullupEnable = regWrData;
        end
        ADDR_PIN_READBACK: begin
          next_cur.outputValue = cur.outputValue;
        end
        default: begin
          next_cur.direction = cur.direction;
        end
      endcase
    end

    // Hardware standby clears the direction, output value and pull-up registers as a power-on reset does
    if (hwStandby) begin
      next_cur.direction = RESET_PIN_DIRECTION;
      next_cur.outputValue = RESET_OUTPUT_VALUE;
      next_cur.pullupEnable = RESET_PULLUP_ENABLE;
    end

    // Pins and readback hold their last value while frozen
    if (!holdState) begin
      next_cur.readback = readbackNow;
      next_cur.pinOut = pinOutNow;
      next_cur.pinOe = pinOeNow;
      next_cur.pullupOn = pullupNow;
    end
    if (hwStandby) begin
      next_cur.readback = pinSync;
      next_cur.pinOe = '0;
      next_cur.pullupOn = '0;
    end

    // Read data stand for the cycle after the strobe only
    next_cur.rdData = '0;
    if (regRd) begin
      case (regAddr)
        ADDR_PIN_DIRECTION: begin
          next_cur.rdData = READ_WRITE_ONLY;
        end
        ADDR_OUTPUT_VALUE: begin
          next_cur.rdData = cur.outputValue;
        end
        ADDR_PIN_READBACK: begin
          next_cur.rdData = cur.readback;
        end
        ADDR_PULLUP_ENABLE: begin
          next_cur.rdData = cur.pullupEnable;
        end
        ADDR_PORT_STATUS: begin
          next_cur.rdData = statusWord;
        end
        default: begin
          next_cur.rdData = READ_UNMAPPED;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge mclk) begin
    if (rst) begin
      cur <= RESET_STATE;
    end else if (ce) begin
      cur <= next_cur;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign regRdData = cur.rdData;
  assign pinOut = cur.pinOut;
  assign pinOe = cur.pinOe;
  assign pullupOn = cur.pullupOn;
  assign busDataIn = cur.busDataIn;

endmodule : port_e_gpio
`default_nettype wire

//--- core/port_e_pkg.sv
package port_e_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Widths
  localparam int PORT_PINS = 8;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 16;
  localparam int MODE_W = 3;
  localparam int SYNC_STAGES = 2;

  ////////////////////////////////////////////////////////////////////////////
  // Register addresses
  localparam logic [ADDR_W-1:0] ADDR_PIN_DIRECTION = 16'hFEBD;
  localparam logic [ADDR_W-1:0] ADDR_OUTPUT_VALUE = 16'hFF6D;
  localparam logic [ADDR_W-1:0] ADDR_PIN_READBACK = 16'hFF5D;
  localparam logic [ADDR_W-1:0] ADDR_PULLUP_ENABLE = 16'hFF74;
  localparam logic [ADDR_W-1:0] ADDR_PORT_STATUS = 16'hFF75;

  ////////////////////////////////////////////////////////////////////////////
  // Reset and read values
  localparam logic [DATA_W-1:0] RESET_PIN_DIRECTION = 8'h00;
  localparam logic [DATA_W-1:0] RESET_OUTPUT_VALUE = 8'h00;
  localparam logic [DATA_W-1:0] RESET_PULLUP_ENABLE = 8'h00;
  localparam logic [DATA_W-1:0] READ_WRITE_ONLY = 8'h00;
  localparam logic [DATA_W-1:0] READ_UNMAPPED = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Status field layout
  localparam int STATUS_OWNER_LSB = 0;
  localparam int STATUS_OWNER_W = 2;
  localparam int STATUS_WIDE_BIT = 2;

  ////////////////////////////////////////////////////////////////////////////
  // Operating modes
  localparam logic [MODE_W-1:0] MODE_0 = 3'h0;
  localparam logic [MODE_W-1:0] MODE_1 = 3'h1;
  localparam logic [MODE_W-1:0] MODE_2 = 3'h2;
  localparam logic [MODE_W-1:0] MODE_3 = 3'h3;
  localparam logic [MODE_W-1:0] MODE_4 = 3'h4;
  localparam logic [MODE_W-1:0] MODE_5 = 3'h5;
  localparam logic [MODE_W-1:0] MODE_6 = 3'h6;
  localparam logic [MODE_W-1:0] MODE_7 = 3'h7;

  ////////////////////////////////////////////////////////////////////////////
  // Pin ownership
  typedef enum logic [1:0] {
    OWN_GPIO = 2'h0,
    OWN_DATABUS = 2'h1,
    OWN_STANDBY = 2'h2
  } owner_e;

endpackage : port_e_pkg

//--- core/pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 8,
  parameter int STAGES = 2
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);

  ////////////////////////////////////////////////////////////////////////////
  // Parameter check
  if (STAGES < 2 || WIDTH < 1) begin : gBadParam
    $error("pin_sync needs at least two stages and one bit");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-bit flip-flop chain
  logic [STAGES-1:0] chain [WIDTH];

  for (genvar i = 0; i < WIDTH; i++) begin : gBit
    always_ff @(posedge mclk) begin
      if (rst) begin
        chain[i] <= '0;
      end else if (ce) begin
        chain[i] <= {chain[i][STAGES-2:0], asyncIn[i]};
      end
    end
    assign syncOut[i] = chain[i][STAGES-1];
  end

endmodule : pin_sync
`default_nettype wire

//--- verification/board_pins.sv
`timescale 1ns/1ps
`default_nettype none
module board_pins (
  input wire logic mclk,
  input wire logic [7:0] pinOut,
  input wire logic [7:0] pinOe,
  input wire logic [7:0] pullupOn,
  input wire logic [7:0] extVal,
  input wire logic [7:0] extOe,
  output logic [7:0] pinIn
);
  logic [7:0] drift = 8'h55;
  // Undriven pins without pull-up wander every cycle
  always @(posedge mclk) drift <= ~drift;
  assign pinIn = (pinOe & pinOut) | (~pinOe & extOe & extVal) | (~pinOe & ~extOe & (pullupOn | drift));
endmodule : board_pins
`default_nettype wire

//--- verification/port_e_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module port_e_monitor (
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  input wire logic hwStandby,
  input wire logic manualReset,
  input wire logic swStandby,
  input wire logic [2:0] opMode,
  input wire logic busWide,
  input wire logic [15:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [7:0] regRdData,
  input wire logic [7:0] pinOut,
  input wire logic [7:0] pinOe,
  input wire logic [7:0] pullupOn,
  input wire logic [7:0] busDataOut,
  input wire logic busDataOe
);
  import port_e_pkg::*;
  logic run;
  logic gw;
  assign run = ce && !hwStandby && !manualReset && !swStandby;
  assign gw = run && !(busWide && !(opMode inside {3'h0, 3'h3, 3'h7}));
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  property p_dir_rd; ce && regRd && regAddr == ADDR_PIN_DIRECTION |=> regRdData == READ_WRITE_ONLY; endproperty
  a_dir_rd: assert property (p_dir_rd) else $error("direction read");
  property p_out_wr; gw && regWr && regAddr == ADDR_OUTPUT_VALUE ##1 run |=> pinOut == $past(regWrData, 2);
  endproperty
  a_out_wr: assert property (p_out_wr) else $error("output drive");
  property p_dir_wr; gw && regWr && regAddr == ADDR_PIN_DIRECTION ##1 run |=> pinOe == $past(regWrData, 2);
  endproperty
  a_dir_wr: assert property (p_dir_wr) else $error("direction drive");
  property p_ro_wr; gw && regWr && regAddr == ADDR_PIN_READBACK && !$past(regWr) ##1 run
    |=> $stable(pinOut) && $stable(pinOe);
  endproperty
  a_ro_wr: assert property (p_ro_wr) else $error("readback write");
  property p_hw; ce && hwStandby |=> pinOe == 8'h00 && pullupOn == 8'h00; endproperty
  a_hw: assert property (p_hw) else $error("standby pins");
  property p_hold; ce && !hwStandby && (manualReset || swStandby)
    |=> $stable(pinOut) && $stable(pinOe) && $stable(pullupOn);
  endproperty
  a_hold: assert property (p_hold) else $error("hold broken");
  property p_pu; (pullupOn & pinOe) == 8'h00; endproperty
  a_pu: assert property (p_pu) else $error("pullup on output");
  property p_wide; run && !gw |=> pinOut == $past(busDataOut) && pinOe == {8{$past(busDataOe)}} && pullupOn == 8'h00;
  endproperty
  a_wide: assert property (p_wide) else $error("data bus pins");
endmodule : port_e_monitor
bind port_e_gpio port_e_monitor mon (.mclk, .rst, .ce, .hwStandby, .manualReset, .swStandby, .opMode, .busWide,
  .regAddr, .regWrData, .regWr, .regRd, .regRdData, .pinOut, .pinOe, .pullupOn, .busDataOut, .busDataOe);
`default_nettype wire

//--- verification/port_e_gpio_tb.sv
`timescale 1ns/1ps
`default_nettype none
module port_e_gpio_tb;
  import port_e_pkg::*;
  logic mclk = 0, rst = 1, ce = 1, hwStandby = 0, manualReset = 0, swStandby = 0;
  logic busWide = 0, regWr = 0, regRd = 0, busDataOe = 0;
  logic [2:0] opMode = 3'h3;
  logic [15:0] regAddr = 16'h0000;
  logic [7:0] regWrData = 8'h00, busDataOut = 8'h00, extVal = 8'h00, extOe = 8'hFF;
  logic [7:0] regRdData, pinIn, pinOut, pinOe, pullupOn, busDataIn, dir, out, pu, m, rb;
  int miscompares = 0, n_compared = 0;
  always #12.5 mclk = ~mclk;
  port_e_gpio uut (.mclk, .rst, .ce, .hwStandby, .manualReset, .swStandby, .opMode, .busWide, .regAddr,
    .regWrData, .regWr, .regRd, .regRdData, .pinIn, .pinOut, .pinOe, .pullupOn, .busDataOut, .busDataOe, .busDataIn);
  board_pins board (.mclk, .pinOut, .pinOe, .pullupOn, .extVal, .extOe, .pinIn);
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge mclk);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge mclk);
    regWr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic [7:0] e, input logic [7:0] mk = 8'hFF);
    @(posedge mclk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge mclk);
    regRd <= 1'b0;
    #1 rb = regRdData;
    chk(rb & mk, e & mk);
  endtask : rd
  function automatic logic [7:0] pins_read(input logic [7:0] dr, od, ev, eo);
    return (dr & od) | (~dr & ((eo & ev) | ~eo));
  endfunction : pins_read
  function automatic logic [7:0] status_word(input logic [2:0] md, input logic wd);
    logic wb;
    wb = wd && !(md inside {3'h0, 3'h3, 3'h7});
    return {5'h00, wb, 2'(wb ? OWN_DATABUS : OWN_GPIO)};
  endfunction : status_word
  task automatic summarize;
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : summarize
  initial begin
    #200000;
    miscompares++;
    summarize();
  end
  initial begin
    m = 8'($urandom(92150));
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    rd(ADDR_OUTPUT_VALUE, RESET_OUTPUT_VALUE);
    rd(ADDR_PULLUP_ENABLE, RESET_PULLUP_ENABLE);
    rd(ADDR_PIN_DIRECTION, READ_WRITE_ONLY);
    rd(16'h1234, READ_UNMAPPED);
    chk(pinOe, RESET_PIN_DIRECTION);
    $display("test reset done");
    for (int i = 0; i < 48; i++) begin
      @(posedge mclk);
      opMode <= 3'(i);
      busWide <= 1'($urandom);
      busDataOe <= 1'($urandom);
      busDataOut <= 8'($urandom);
      extVal <= 8'($urandom);
      extOe <= 8'($urandom);
      dir = (i < 8) ? 8'h00 : 8'($urandom);
      pu = (i < 8) ? 8'hFF : 8'($urandom);
      out = 8'($urandom);
      wr(ADDR_PIN_DIRECTION, dir);
      wr(ADDR_OUTPUT_VALUE, out);
      wr(ADDR_PULLUP_ENABLE, pu);
      wr(ADDR_PIN_READBACK, ~out);
      repeat (4) @(posedge mclk);
      #1;
      if (busWide && !(opMode inside {3'h0, 3'h3, 3'h7})) begin
        chk(pinOe, {8{busDataOe}});
        chk(pinOut, busDataOut);
        chk(pullupOn, 8'h00);
        if (!busDataOe) chk(busDataIn & extOe, extVal & extOe);
        else chk(busDataIn, busDataOut);
      end else begin
        chk(pinOe, dir);
        chk(pinOut, out);
        chk(pullupOn, ~dir & pu);
        rd(ADDR_PIN_READBACK, pins_read(dir, out, extVal, extOe), dir | extOe | pu);
      end
      rd(ADDR_OUTPUT_VALUE, out);
      rd(ADDR_PULLUP_ENABLE, pu);
      rd(ADDR_PORT_STATUS, status_word(opMode, busWide));
    end
    $display("test random done");
    @(posedge mclk);
    {opMode, busWide, extOe} <= {3'h7, 1'b0, 8'hFF};
    wr(ADDR_OUTPUT_VALUE, 8'h3C);
    @(posedge mclk);
    ce <= 1'b0;
    wr(ADDR_OUTPUT_VALUE, 8'hC3);
    repeat (2) @(posedge mclk);
    #1;
    chk(pinOut, 8'h3C);
    @(posedge mclk);
    ce <= 1'b1;
    rd(ADDR_OUTPUT_VALUE, 8'h3C);
    $display("test clock enable done");
    for (int k = 0; k < 4; k++) begin
      wr(ADDR_PIN_DIRECTION, 8'h0F);
      wr(ADDR_OUTPUT_VALUE, 8'hA5);
      wr(ADDR_PULLUP_ENABLE, 8'hF0);
      repeat (4) @(posedge mclk);
      rd(ADDR_PIN_READBACK, pins_read(8'h0F, 8'hA5, extVal, extOe));
      m = rb;
      @(posedge mclk);
      {manualReset, swStandby, hwStandby, rst} <= 4'h8 >> k;
      extVal <= ~extVal;
      if (k < 3) wr(ADDR_OUTPUT_VALUE, 8'h5A);
      repeat (3) @(posedge mclk);
      #1;
      chk(pinOe, (k < 2) ? 8'h0F : 8'h00);
      chk(pullupOn, (k < 2) ? 8'hF0 : 8'h00);
      if (k == 2) rd(ADDR_PORT_STATUS, 8'(OWN_STANDBY));
      if (k < 2) begin
        chk(pinOut, 8'hA5);
        rd(ADDR_PIN_READBACK, m);
        rd(ADDR_OUTPUT_VALUE, 8'hA5);
      end
      @(posedge mclk);
      {manualReset, swStandby, hwStandby, rst} <= 4'h0;
      if (k >= 2) begin
        rd(ADDR_OUTPUT_VALUE, RESET_OUTPUT_VALUE);
        rd(ADDR_PULLUP_ENABLE, RESET_PULLUP_ENABLE);
        rd(ADDR_PIN_READBACK, extVal);
      end
      $display("test hold kind %0d done", k);
    end
    summarize();
  end
endmodule : port_e_gpio_tb
`default_nettype wire
